// file: pkg/fndc_map.svh
// Constants of the fractional-N divider control: word layouts, codes, widths
// Function
// - Word bits 12:2 give extender bits 14:4
// - First frequency word 23:20 gives extender 3:0
// - Word bits 20:13 give fractional code
// - Auto-tune fields placed in bits 2 to 20
// - Modulator picks low or high modulus
// - Select bit 23: 0 gives 8/9, 1 gives 16/17
// - Six-bit low and four-bit high counters
// - Six-bit counts low, four-bit counts high
// - Counter setting updated every comparison cycle
// - Third-order cascaded modulator randomizes ratio
// - Divider brings prescaler down to comparison rate
// - Counter loads reloaded cycle by cycle
// - Bit 18: 0 integer, 1 fractional mode
// - Lock indicator high while frequency locked
// - Indicator pin may carry divider or test outputs
// - Codes 000 lock, 001 ref, 010 N, 111 test
`ifndef FNDC_MAP_SVH
`define FNDC_MAP_SVH

`define FNDC_WORD_W        26
`define FNDC_ADR_HI        1
`define FNDC_ADR_LO        0
`define FNDC_ADR_SETUP     2'h0
`define FNDC_ADR_AUTOTUNE  2'h1
`define FNDC_ADR_FREQ1     2'h2
`define FNDC_ADR_FREQ2     2'h3

`define FNDC_W0_PSEL       23
`define FNDC_W0_MUX_HI     17
`define FNDC_W0_MUX_LO     15

`define FNDC_W1_CDLY_HI    3
`define FNDC_W1_CDLY_LO    2
`define FNDC_W1_TEMP_HI    8
`define FNDC_W1_TEMP_LO    4
`define FNDC_W1_TEMP_EN    9
`define FNDC_W1_EXT_HI     17
`define FNDC_W1_EXT_LO     10
`define FNDC_W1_OVR        18
`define FNDC_W1_VAL        19
`define FNDC_W1_EN         20

`define FNDC_W2_RDIV_HI    3
`define FNDC_W2_RDIV_LO    2
`define FNDC_W2_NDIV_HI    15
`define FNDC_W2_NDIV_LO    6
`define FNDC_W2_MODON      17
`define FNDC_W2_FRAC       18
`define FNDC_W2_ME_HI      23
`define FNDC_W2_ME_LO      20

`define FNDC_W3_ME_HI      12
`define FNDC_W3_ME_LO      2
`define FNDC_W3_FN_HI      20
`define FNDC_W3_FN_LO      13

`define FNDC_MUX_LOCK      3'h0
`define FNDC_MUX_REF       3'h1
`define FNDC_MUX_NDIV      3'h2
`define FNDC_MUX_TEST      3'h7

`define FNDC_RDIV_8        2'h0
`define FNDC_RDIV_4        2'h1
`define FNDC_RDIV_2        2'h2
`define FNDC_RDIV_1        2'h3
`define FNDC_RCNT_8        3'h7
`define FNDC_RCNT_4        3'h3
`define FNDC_RCNT_2        3'h1
`define FNDC_RCNT_1        3'h0

`define FNDC_M_W           6
`define FNDC_A_W           4
`define FNDC_NDIV_W        10
`define FNDC_ME_W          15
`define FNDC_FN_W          8
`define FNDC_FRAC_W        23
`define FNDC_NCYC_W        11
`define FNDC_SYNC_W        3

`endif

// file: pkg/fndc_pkg.sv
// Types of the fractional-N divider control
`include "fndc_map.svh"
package fndc_pkg;

    typedef logic [`FNDC_SYNC_W-1:0] fndc_sync_t;

    typedef struct packed {
        fndc_sync_t                 sclk_s;
        fndc_sync_t                 sdat_s;
        fndc_sync_t                 le_s;
        fndc_sync_t                 pre_s;
        fndc_sync_t                 ref_s;
        fndc_sync_t                 lock_s;
        fndc_sync_t                 tst_s;
        logic                       sclk_f;
        logic                       sdat_f;
        logic                       le_f;
        logic                       pre_f;
        logic                       ref_f;
        logic                       lock_f;
        logic                       tst_f;
        logic [`FNDC_WORD_W-1:0]    shift;
        logic                       psel;
        logic [2:0]                 mux_sel;
        logic [1:0]                 at_cdly;
        logic [4:0]                 at_temp;
        logic                       at_temp_en;
        logic [7:0]                 at_ext;
        logic                       at_ovr;
        logic                       at_val;
        logic                       at_en;
        logic [1:0]                 rdiv;
        logic [`FNDC_NDIV_W-1:0]    ndiv;
        logic                       mod_on;
        logic                       frac_sel;
        logic [3:0]                 me_lo;
        logic [10:0]                me_hi;
        logic [`FNDC_FN_W-1:0]      fn;
        logic                       pend;
        logic [`FNDC_NDIV_W-1:0]    act_ndiv;
        logic [`FNDC_FRAC_W-1:0]    act_frac;
        logic                       act_frac_sel;
        logic                       act_mod_on;
        logic                       act_p16;
        logic [`FNDC_FRAC_W-1:0]    acc1;
        logic [`FNDC_FRAC_W-1:0]    acc2;
        logic [`FNDC_FRAC_W-1:0]    acc3;
        logic                       c2d;
        logic                       c3d;
        logic                       c3dd;
        logic [2:0]                 rcnt;
        logic                       ref_tick;
        logic                       ndiv_pulse;
        logic                       pin;
        logic                       word_load;
    } fndc_state_t;

    typedef struct packed {
        logic [`FNDC_M_W-1:0]       cnt;
    } fndc_cnt_state_t;

endpackage

// file: logic/fndc_down_counter.sv
// Loadable down counter used for the low and high modulus counts
`timescale 1ns/1ps
`default_nettype none
module fndc_down_counter #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         dec_i,
    // State
    output logic      [W-1:0] cnt_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load_i)
        begin
            cnt_nxt = load_val_i;
        end
        else if (dec_i && (cnt_r != '0))
        begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    assign cnt_o = cnt_r;
endmodule
`default_nettype wire

// file: logic/fndc_top.sv
// Fractional-N feedback divider control with three-wire serial programming
`timescale 1ns/1ps
`default_nettype none
`include "fndc_map.svh"
module fndc_top (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Three-wire serial port
    input  wire logic        ser_clk_i,
    input  wire logic        ser_data_i,
    input  wire logic        ser_le_i,
    // Prescaler and reference
    input  wire logic        prescaler_out_i,
    input  wire logic        ref_clk_i,
    output logic             mod_high_o,
    output logic             prescaler_16_o,
    output logic             ref_div_pulse_o,
    output logic             ndiv_pulse_o,
    // Lock and test
    input  wire logic        lock_detect_i,
    input  wire logic        autotune_test_i,
    output logic             lock_indicator_pin_o,
    // Auto-tune loop fields
    output logic [1:0]       at_clk_dly_o,
    output logic [4:0]       at_temp_comp_o,
    output logic             at_temp_comp_en_o,
    output logic [7:0]       at_ext_test_o,
    output logic             at_flag_override_o,
    output logic             at_flag_value_o,
    output logic             at_enable_o,
    // Status
    output logic             word_load_o
);
    import fndc_pkg::*;

    fndc_state_t             st_r;
    fndc_state_t             st_nxt;
    logic [`FNDC_M_W-1:0]    m_cnt;
    logic [`FNDC_A_W-1:0]    a_cnt;
    logic                    pre_rise;
    logic                    div_end;
    logic [`FNDC_M_W-1:0]    m_load;
    logic [`FNDC_A_W-1:0]    a_load;

    // Filtered prescaler rise, the same edge that the divide logic sees
    assign pre_rise = st_r.pre_s[1] && st_r.pre_s[2] && !st_r.pre_f;

    always_comb
    begin
        logic                     sclk_rise;
        logic                     le_rise;
        logic                     ref_rise;
        logic                     prise;
        logic [1:0]               adr;
        logic [`FNDC_FRAC_W:0]    s1;
        logic [`FNDC_FRAC_W:0]    s2;
        logic [`FNDC_FRAC_W:0]    s3;
        logic [3:0]               dn;
        logic [`FNDC_NCYC_W-1:0]  nbase;
        logic [`FNDC_NCYC_W-1:0]  ncyc;
        sclk_rise = 1'b0;
        le_rise   = 1'b0;
        ref_rise  = 1'b0;
        prise     = 1'b0;
        adr       = 2'h0;
        s1        = '0;
        s2        = '0;
        s3        = '0;
        dn        = 4'h0;
        nbase     = '0;
        ncyc      = '0;
        st_nxt    = st_r;

        // Pin synchronisers with agreement filter
        st_nxt.sclk_s = {st_r.sclk_s[1:0], ser_clk_i};
        st_nxt.sdat_s = {st_r.sdat_s[1:0], ser_data_i};
        st_nxt.le_s   = {st_r.le_s[1:0], ser_le_i};
        st_nxt.pre_s  = {st_r.pre_s[1:0], prescaler_out_i};
        st_nxt.ref_s  = {st_r.ref_s[1:0], ref_clk_i};
        st_nxt.lock_s = {st_r.lock_s[1:0], lock_detect_i};
        st_nxt.tst_s  = {st_r.tst_s[1:0], autotune_test_i};
        if (st_r.sclk_s[1] == st_r.sclk_s[2])
        begin
            st_nxt.sclk_f = st_r.sclk_s[2];
        end
        if (st_r.sdat_s[1] == st_r.sdat_s[2])
        begin
            st_nxt.sdat_f = st_r.sdat_s[2];
        end
        if (st_r.le_s[1] == st_r.le_s[2])
        begin
            st_nxt.le_f = st_r.le_s[2];
        end
        if (st_r.pre_s[1] == st_r.pre_s[2])
        begin
            st_nxt.pre_f = st_r.pre_s[2];
        end
        if (st_r.ref_s[1] == st_r.ref_s[2])
        begin
            st_nxt.ref_f = st_r.ref_s[2];
        end
        if (st_r.lock_s[1] == st_r.lock_s[2])
        begin
            st_nxt.lock_f = st_r.lock_s[2];
        end
        if (st_r.tst_s[1] == st_r.tst_s[2])
        begin
            st_nxt.tst_f = st_r.tst_s[2];
        end
        sclk_rise = st_nxt.sclk_f && !st_r.sclk_f;
        le_rise   = st_nxt.le_f && !st_r.le_f;
        ref_rise  = st_nxt.ref_f && !st_r.ref_f;
        prise     = st_nxt.pre_f && !st_r.pre_f;

        // Serial shift, most significant bit first
        if (sclk_rise)
        begin
            st_nxt.shift = {st_r.shift[`FNDC_WORD_W-2:0], st_r.sdat_f};
        end

        // Word decode on the latch edge
        st_nxt.word_load = le_rise;
        adr = st_r.shift[`FNDC_ADR_HI:`FNDC_ADR_LO];
        if (le_rise)
        begin
            unique case (adr)
                `FNDC_ADR_SETUP:
                begin
                    st_nxt.psel    = st_r.shift[`FNDC_W0_PSEL];
                    st_nxt.mux_sel = st_r.shift[`FNDC_W0_MUX_HI:`FNDC_W0_MUX_LO];
                end
                `FNDC_ADR_AUTOTUNE:
                begin
                    st_nxt.at_cdly    = st_r.shift[`FNDC_W1_CDLY_HI:`FNDC_W1_CDLY_LO];
                    st_nxt.at_temp    = st_r.shift[`FNDC_W1_TEMP_HI:`FNDC_W1_TEMP_LO];
                    st_nxt.at_temp_en = st_r.shift[`FNDC_W1_TEMP_EN];
                    st_nxt.at_ext     = st_r.shift[`FNDC_W1_EXT_HI:`FNDC_W1_EXT_LO];
                    st_nxt.at_ovr     = st_r.shift[`FNDC_W1_OVR];
                    st_nxt.at_val     = st_r.shift[`FNDC_W1_VAL];
                    st_nxt.at_en      = st_r.shift[`FNDC_W1_EN];
                end
                `FNDC_ADR_FREQ1:
                begin
                    st_nxt.rdiv     = st_r.shift[`FNDC_W2_RDIV_HI:`FNDC_W2_RDIV_LO];
                    st_nxt.ndiv     = st_r.shift[`FNDC_W2_NDIV_HI:`FNDC_W2_NDIV_LO];
                    st_nxt.mod_on   = st_r.shift[`FNDC_W2_MODON];
                    st_nxt.frac_sel = st_r.shift[`FNDC_W2_FRAC];
                    st_nxt.me_lo    = st_r.shift[`FNDC_W2_ME_HI:`FNDC_W2_ME_LO];
                    st_nxt.pend     = 1'b1;
                end
                `FNDC_ADR_FREQ2:
                begin
                    st_nxt.me_hi = st_r.shift[`FNDC_W3_ME_HI:`FNDC_W3_ME_LO];
                    st_nxt.fn    = st_r.shift[`FNDC_W3_FN_HI:`FNDC_W3_FN_LO];
                    st_nxt.pend  = 1'b1;
                end
            endcase
        end

        // Reference divider by 8, 4, 2 or 1
        st_nxt.ref_tick = 1'b0;
        if (ref_rise)
        begin
            if (st_r.rcnt == 3'h0)
            begin
                st_nxt.ref_tick = 1'b1;
                unique case (st_r.rdiv)
                    `FNDC_RDIV_8: st_nxt.rcnt = `FNDC_RCNT_8;
                    `FNDC_RDIV_4: st_nxt.rcnt = `FNDC_RCNT_4;
                    `FNDC_RDIV_2: st_nxt.rcnt = `FNDC_RCNT_2;
                    `FNDC_RDIV_1: st_nxt.rcnt = `FNDC_RCNT_1;
                endcase
            end
            else
            begin
                st_nxt.rcnt = st_r.rcnt - 3'h1;
            end
        end

        // Third-order cascaded sigma-delta, one step per divide cycle
        s1 = {1'b0, st_r.acc1} + {1'b0, st_r.act_frac};
        s2 = {1'b0, st_r.acc2} + {1'b0, s1[`FNDC_FRAC_W-1:0]};
        s3 = {1'b0, st_r.acc3} + {1'b0, s2[`FNDC_FRAC_W-1:0]};
        dn = 4'(s1[`FNDC_FRAC_W]) + 4'(s2[`FNDC_FRAC_W]) - 4'(st_r.c2d)
           + 4'(s3[`FNDC_FRAC_W]) - 4'({st_r.c3d, 1'b0}) + 4'(st_r.c3dd);
        if (!st_r.act_frac_sel || !st_r.act_mod_on)
        begin
            dn = 4'h0;
        end

        // Integer ratio from the low and high counter fields
        if (st_r.act_p16)
        begin
            nbase = {1'b0, st_r.act_ndiv};
        end
        else
        begin
            nbase = {2'h0, st_r.act_ndiv[`FNDC_NDIV_W-1:4], st_r.act_ndiv[2:0]};
        end
        ncyc = nbase + {{(`FNDC_NCYC_W-4){dn[3]}}, dn};

        // Split the cycle ratio into low and high modulus counts
        if (st_r.act_p16)
        begin
            m_load = ncyc[9:4];
            a_load = ncyc[3:0];
        end
        else
        begin
            m_load = ncyc[8:3];
            a_load = {1'b0, ncyc[2:0]};
        end

        div_end = (prise && (m_cnt <= `FNDC_M_W'(1))) || (m_cnt == '0);
        st_nxt.ndiv_pulse = div_end;
        if (div_end)
        begin
            st_nxt.c2d  = s2[`FNDC_FRAC_W];
            st_nxt.c3d  = s3[`FNDC_FRAC_W];
            st_nxt.c3dd = st_r.c3d;
            st_nxt.acc1 = s1[`FNDC_FRAC_W-1:0];
            st_nxt.acc2 = s2[`FNDC_FRAC_W-1:0];
            st_nxt.acc3 = s3[`FNDC_FRAC_W-1:0];
            if (st_r.pend && !le_rise)
            begin
                st_nxt.pend         = 1'b0;
                st_nxt.act_ndiv     = st_r.ndiv;
                st_nxt.act_frac     = {st_r.fn, st_r.me_hi, st_r.me_lo};
                st_nxt.act_frac_sel = st_r.frac_sel;
                st_nxt.act_mod_on   = st_r.mod_on;
            end
            st_nxt.act_p16 = st_r.psel;
        end
        if (!st_r.act_mod_on)
        begin
            st_nxt.acc1 = '0;
            st_nxt.acc2 = '0;
            st_nxt.acc3 = '0;
            st_nxt.c2d  = 1'b0;
            st_nxt.c3d  = 1'b0;
            st_nxt.c3dd = 1'b0;
        end

        // Lock indicator pin source
        unique case (st_r.mux_sel)
            `FNDC_MUX_LOCK: st_nxt.pin = st_r.lock_f;
            `FNDC_MUX_REF:  st_nxt.pin = st_r.ref_tick;
            `FNDC_MUX_NDIV: st_nxt.pin = st_r.ndiv_pulse;
            `FNDC_MUX_TEST: st_nxt.pin = st_r.tst_f;
            default:        st_nxt.pin = 1'b0;
        endcase
    end

    // Low-modulus total count and high-modulus count
    fndc_down_counter #(
        .W          (`FNDC_M_W)
    ) u_m_cnt (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .load_i     (div_end),
        .load_val_i (m_load),
        .dec_i      (pre_rise),
        .cnt_o      (m_cnt)
    );

    fndc_down_counter #(
        .W          (`FNDC_A_W)
    ) u_a_cnt (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .load_i     (div_end),
        .load_val_i (a_load),
        .dec_i      (pre_rise),
        .cnt_o      (a_cnt)
    );

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign mod_high_o           = (a_cnt != '0);
    assign prescaler_16_o       = st_r.act_p16;
    assign ref_div_pulse_o      = st_r.ref_tick;
    assign ndiv_pulse_o         = st_r.ndiv_pulse;
    assign lock_indicator_pin_o = st_r.pin;
    assign at_clk_dly_o         = st_r.at_cdly;
    assign at_temp_comp_o       = st_r.at_temp;
    assign at_temp_comp_en_o    = st_r.at_temp_en;
    assign at_ext_test_o        = st_r.at_ext;
    assign at_flag_override_o   = st_r.at_ovr;
    assign at_flag_value_o      = st_r.at_val;
    assign at_enable_o          = st_r.at_en;
    assign word_load_o          = st_r.word_load;
endmodule
`default_nettype wire

// file: logic/fndc_fix.sv
// (empty)

// file: test/fndc_monitor.sv
// Port checker of the divider control, attached to the top by bind
`timescale 1ns/1ps
`default_nettype none
module fndc_monitor (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       ser_le_i,
    input wire logic       word_load_o,
    input wire logic [1:0] at_clk_dly_o,
    input wire logic [4:0] at_temp_comp_o,
    input wire logic       at_temp_comp_en_o,
    input wire logic [7:0] at_ext_test_o,
    input wire logic       at_flag_override_o,
    input wire logic       at_flag_value_o,
    input wire logic       at_enable_o,
    input wire logic       prescaler_16_o,
    input wire logic       ndiv_pulse_o,
    input wire logic       ref_div_pulse_o,
    input wire logic       mod_high_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    a_load_one_cycle: assert property (word_load_o |=> !word_load_o)
        else $error("word load pulse longer than one cycle");
    a_load_after_latch: assert property ($rose(ser_le_i) |-> ##[2:8] word_load_o)
        else $error("no word load after latch edge");
    a_load_needs_latch: assert property (word_load_o |-> $past(ser_le_i, 2))
        else $error("word load without latch");
    a_tune_on_load: assert property (
        $changed({at_clk_dly_o, at_temp_comp_o, at_temp_comp_en_o, at_ext_test_o}) |-> word_load_o)
        else $error("auto-tune field changed without load");
    a_flags_on_load: assert property (
        !word_load_o |-> $stable({at_flag_override_o, at_flag_value_o, at_enable_o}))
        else $error("auto-tune flag changed without load");
    a_mode_at_end: assert property ($changed(prescaler_16_o) |-> (##[0:2] ndiv_pulse_o)
        or $past(ndiv_pulse_o) or $past(ndiv_pulse_o, 2))
        else $error("prescaler mode changed outside divide end");
    a_ref_pulse_gap: assert property (ref_div_pulse_o |=> !ref_div_pulse_o [*5])
        else $error("reference divider pulses too close");
    a_high_holds: assert property ($rose(mod_high_o) |=> mod_high_o [*4])
        else $error("high modulus dropped before a prescaler cycle");
endmodule
bind fndc_top fndc_monitor u_mon (
    .mclk_i(mclk_i), .rst_i(rst_i), .ser_le_i(ser_le_i), .word_load_o(word_load_o),
    .at_clk_dly_o(at_clk_dly_o), .at_temp_comp_o(at_temp_comp_o),
    .at_temp_comp_en_o(at_temp_comp_en_o), .at_ext_test_o(at_ext_test_o),
    .at_flag_override_o(at_flag_override_o), .at_flag_value_o(at_flag_value_o),
    .at_enable_o(at_enable_o), .prescaler_16_o(prescaler_16_o), .ndiv_pulse_o(ndiv_pulse_o),
    .ref_div_pulse_o(ref_div_pulse_o), .mod_high_o(mod_high_o)
);
`default_nettype wire

// file: test/fndc_host_model.sv
// Host side of the three-wire programming port
`timescale 1ns/1ps
`default_nettype none
module fndc_host_model (
    // Clock
    input  wire logic mclk_i,
    // Serial port pins
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      ser_le_o
);
    initial
    begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
        ser_le_o = 1'b0;
    end
    // Sends one word MSB first, every pin level held at least four cycles
    task automatic send(input logic [25:0] w);
        int i;
        for (i = 25; i >= 0; i--)
        begin
            @(negedge mclk_i);
            ser_data_o = w[i];
            repeat (4) @(negedge mclk_i);
            ser_clk_o = 1'b1;
            repeat (4) @(negedge mclk_i);
            ser_clk_o = 1'b0;
        end
        repeat (4) @(negedge mclk_i);
        ser_data_o = ~w[0];
        ser_le_o = 1'b1;
        repeat (10) @(negedge mclk_i);
        ser_le_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/fndc_top_tb_top.sv
// Self-checking testbench of the divider control
`timescale 1ns/1ps
`default_nettype none
module fndc_top_tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ser_clk, ser_data, ser_le, mod_high, p16, ref_pulse, ndiv_pulse, pin, word_load;
    logic        pre_i = 1'b0, ref_i = 1'b0, lock_i = 1'b0, test_i = 1'b0;
    wire  [18:0] at_v;
    logic [18:0] at_exp = '0;
    logic [18:0] q[$];
    int          num_errors = 0, n_compared = 0, rises = 0, pc = 0;

    fndc_host_model host (.mclk_i(mclk_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
        .ser_le_o(ser_le));
    fndc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
        .ser_le_i(ser_le), .prescaler_out_i(pre_i), .ref_clk_i(ref_i), .mod_high_o(mod_high),
        .prescaler_16_o(p16), .ref_div_pulse_o(ref_pulse), .ndiv_pulse_o(ndiv_pulse),
        .lock_detect_i(lock_i), .autotune_test_i(test_i), .lock_indicator_pin_o(pin),
        .at_clk_dly_o(at_v[1:0]), .at_temp_comp_o(at_v[6:2]), .at_temp_comp_en_o(at_v[7]),
        .at_ext_test_o(at_v[15:8]), .at_flag_override_o(at_v[16]), .at_flag_value_o(at_v[17]),
        .at_enable_o(at_v[18]), .word_load_o(word_load));

    initial
    begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // Prescaler period 8 cycles, reference period 10 cycles
    // Each prescaler cycle stands for 8 or 16 input cycles, one more at high modulus
    always @(negedge mclk_i)
    begin
        pc = pc + 1;
        if (pc % 4 == 0)
        begin
            pre_i = ~pre_i;
            if (pre_i)
                rises = rises + (p16 ? 16 : 8) + 32'(mod_high);
        end
        if (pc % 5 == 0)
            ref_i = ~ref_i;
    end
    always @(negedge mclk_i)
        if (!rst_i && word_load === 1'b1)
        begin
            if (q.size() == 0)
                chk("word_load", 0, 1);
            else
                chk("at_fields", 32'(q.pop_front()), 32'(at_v));
        end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (exp !== got)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo;
        num_errors++;
        $display("BAD wait expected event seen none");
        results();
    endtask
    task automatic wr(input logic [25:0] w);
        int i;
        if (w[1:0] == 2'h1)
            at_exp = w[20:2];
        q.push_back(at_exp);
        host.send(w);
        for (i = 0; i < 100 && q.size() > 0; i++)
            @(negedge mclk_i);
        if (q.size() > 0)
            tmo();
    endtask
    // First frequency word with reference divide by one and modulator on
    function automatic logic [25:0] f1(input int nd, input int fr, input int me);
        return 26'((me << 20) | (1 << 19) | (fr << 18) | (1 << 17) | (nd << 6) | 14);
    endfunction
    // Second frequency word, top bits left zero
    function automatic logic [25:0] f2(input int fn, input int mh);
        return 26'((fn << 13) | (mh << 2) | 3);
    endfunction
    task automatic wait_ndiv;
        int i;
        @(negedge mclk_i);
        for (i = 0; i < 3000 && ndiv_pulse !== 1'b1; i++)
            @(negedge mclk_i);
        if (ndiv_pulse !== 1'b1)
            tmo();
        #1;
    endtask
    // Counts input cycles of consecutive divide cycles
    task automatic run_div(input int base, input int cnt, input int frac);
        int r0, n, sum, odd, k;
        sum = 0;
        odd = 0;
        repeat (3) wait_ndiv();
        r0 = rises;
        for (k = 0; k < cnt; k++)
        begin
            wait_ndiv();
            n = rises - r0;
            r0 = rises;
            sum += n;
            odd += 32'(n != base);
            if (frac == 0)
                chk("n_ratio", base, n);
            else
                chk("n_range", 1, 32'(n >= base - 3 && n <= base + 4));
        end
        if (frac != 0)
        begin
            chk("frac_mean", 1, 32'(sum >= cnt * base + cnt / 2 - 4
                && sum <= cnt * base + cnt / 2 + 4));
            chk("frac_spread", 1, 32'(odd > 0));
        end
    endtask

    initial
    begin
        int k, c, np, nr, nn, e;
        k = $urandom(32'hf607990b);
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        for (k = 0; k < 3; k++)
            wr(26'(($urandom() & 32'h1ffffc) | 1));
        wr(26'h1);
        wr(26'h0);
        wr(f1(255, 0, 0));
        wr(f2(128, $urandom() & 32'h7ff));
        run_div(127, 2, 0);
        chk("prescaler_16", 0, 32'(p16));
        for (c = 0; c < 8; c++)
        begin
            lock_i = (c != 7);
            test_i = (c != 0);
            wr(26'(c << 15));
            repeat (10) @(negedge mclk_i);
            np = 0;
            nr = 0;
            nn = 0;
            repeat (1100)
            begin
                @(negedge mclk_i);
                np += 32'(pin === 1'b1);
                nr += 32'(ref_pulse === 1'b1);
                nn += 32'(ndiv_pulse === 1'b1);
            end
            e = (c == 0 || c == 7) ? 1100 : (c == 1) ? nr : (c == 2) ? nn : 0;
            if (c == 1)
                chk("ref_count", 1, 32'(nr >= 109 && nr <= 111));
            chk("pin_select", 1, 32'(np >= e - 1 && np <= e + 1 && (np > 0) == (e > 0)));
        end
        wr(26'h800000);
        wr(f1(243, 0, 0));
        run_div(243, 2, 0);
        chk("prescaler_16", 1, 32'(p16));
        wr(26'h0);
        wr(f1(255, 1, $urandom() & 15));
        run_div(127, 16, 1);
        results();
    end
endmodule
`default_nettype wire
